// >>> hdl/e1_loopback_alarm_control.v
// Loopback routing, automatic alarms and clock selection for one E1 channel.
`timescale 1ns/100ps
`include "e1_loopback_alarm_control_regs.vh"
module e1_loopback_alarm_control #(
    parameter ONE_SECOND_CYCLES = `ONE_SECOND_CYCLES,
    parameter FAST_UPDATE_CYCLES = `FAST_UPDATE_CYCLES,
    parameter CRC4_SHORT_CYCLES = `CRC4_SHORT_CYCLES,
    parameter CRC4_LONG_CYCLES = `CRC4_LONG_CYCLES,
    parameter TX_CLOCK_LOSS_CYCLES = `TX_CLOCK_LOSS_CYCLES,
    parameter MASTER_CLOCK_DIV = `MASTER_CLOCK_DIV
) (
    input wire clk,
    input wire reset_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    output reg [7:0] regRdData,
    input wire frameStart,
    input wire tx_clock_in,
    input wire rxRecoveredClock,
    input wire rx_line_pos_in,
    input wire rx_line_neg_in,
    input wire txFormPos,
    input wire txFormNeg,
    input wire rxSerialIn,
    input wire frameAlignLost,
    input wire aisReceived,
    input wire fasSync,
    input wire crc4MultiframeSync,
    input wire bpvEvent,
    input wire cvEvent,
    input wire [4:0] txChanNum,
    input wire [7:0] txChanData,
    input wire txChanValid,
    output reg tx_line_pos_out,
    output reg tx_line_neg_out,
    output reg rxFramerPos,
    output reg rxFramerNeg,
    output reg rxClockOut,
    output reg rx_serial_out,
    output reg rx_carrier_loss,
    output reg txAisActive,
    output reg txRemoteAlarm,
    output reg txClockFromRecovered,
    output reg txClockLost,
    output reg violationEvent,
    output reg errCountLatch,
    output reg [15:0] violationCountLatched,
    output reg [7:0] tx_monitor_register
);

    // Host-visible control bytes and the copies that steer the logic.
    reg [7:0] common_control_one;
    reg [7:0] common_control_two;
    reg [7:0] common_control_three;
    reg [7:0] activeOne;
    reg [7:0] activeTwo;
    reg [7:0] activeThree;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            common_control_one <= `CTRL_RESET;
            common_control_two <= `CTRL_RESET;
            common_control_three <= `CTRL_RESET;
            regRdData <= 8'h00;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `REG_CTRL_ONE: common_control_one <= regWrData;
                    `REG_CTRL_TWO: common_control_two <= regWrData;
                    `REG_CTRL_THREE: common_control_three <= regWrData;
                    default: ;
                endcase
            end
            case (regAddr)
                `REG_CTRL_ONE: regRdData <= common_control_one;
                `REG_CTRL_TWO: regRdData <= common_control_two;
                `REG_CTRL_THREE: regRdData <= common_control_three;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // New settings are adopted only at a frame boundary so a frame is never split.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activeOne <= `CTRL_RESET;
            activeTwo <= `CTRL_RESET;
            activeThree <= `CTRL_RESET;
        end else if (frameStart) begin
            activeOne <= common_control_one;
            activeTwo <= common_control_two;
            activeThree <= common_control_three;
        end
    end

    wire framerLoopback = activeOne[`BIT_FRAMER_LOOPBACK];
    wire rxCrc4Enable = activeOne[`BIT_RX_CRC4_ENABLE];
    wire fastUpdate = activeTwo[`BIT_ERR_COUNT_UPDATE_SEL];
    wire countCodeViol = activeTwo[`BIT_VIOLATION_COUNT_FUNC_SEL];
    wire autoAis = activeTwo[`BIT_AUTO_AIS_ENABLE];
    wire autoRemote = activeTwo[`BIT_AUTO_REMOTE_ALARM_ENABLE];
    wire serialForce = activeTwo[`BIT_RX_SERIAL_OUT_FORCE];
    wire clockLossMux = activeTwo[`BIT_TX_CLOCK_LOSS_MUX];
    wire altCriteria = activeTwo[`BIT_CARRIER_LOSS_ALT_CRITERIA];
    wire clockSourceSel = activeTwo[`BIT_TX_CLOCK_SOURCE_SEL];
    wire remoteLoopback = activeThree[`BIT_REMOTE_LOOPBACK];
    wire localLoopback = activeThree[`BIT_LOCAL_LOOPBACK];
    wire lineAis = activeThree[`BIT_LINE_AIS_ENABLE];
    wire [4:0] monitorChan = activeThree[`TX_CHAN_MONITOR_MSB:`TX_CHAN_MONITOR_LSB];

    // Pins from outside pass two flip-flops; the third stage only serves edge detection.
    reg [3:0] pinMeta;
    reg [3:0] pinSync;
    reg [1:0] clockLast;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
            clockLast <= 2'h0;
        end else begin
            pinMeta <= {rx_line_neg_in, rx_line_pos_in, rxRecoveredClock, tx_clock_in};
            pinSync <= pinMeta;
            clockLast <= pinSync[1:0];
        end
    end

    wire txClockLevel = pinSync[0];
    wire rxClockLevel = pinSync[1];
    wire lineRxPos = pinSync[2];
    wire lineRxNeg = pinSync[3];
    wire txEdge = txClockLevel & ~clockLast[0];
    wire rxEdge = rxClockLevel & ~clockLast[1];

    // Transmit clock watchdog: no rising edge for the limit means the clock has stopped.
    reg [15:0] txIdleCount;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txIdleCount <= 16'h0000;
            txClockLost <= 1'b0;
        end else if (txEdge) begin
            txIdleCount <= 16'h0000;
            txClockLost <= 1'b0;
        end else if (txIdleCount >= TX_CLOCK_LOSS_CYCLES[15:0] - 16'h0001) begin
            txClockLost <= 1'b1;
        end else begin
            txIdleCount <= txIdleCount + 16'h0001;
        end
    end

    wire next_fromRecovered = clockSourceSel | (clockLossMux & txClockLost);
    wire formatterTick = txClockFromRecovered ? rxEdge : txEdge;

    // Master clock rate enable for unframed all ones on the line.
    reg [7:0] masterDiv;
    reg masterTick;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            masterDiv <= 8'h00;
            masterTick <= 1'b0;
        end else if (masterDiv >= MASTER_CLOCK_DIV[7:0] - 8'h01) begin
            masterDiv <= 8'h00;
            masterTick <= 1'b1;
        end else begin
            masterDiv <= masterDiv + 8'h01;
            masterTick <= 1'b0;
        end
    end

    // Carrier loss: consecutive zero count on the received line.
    reg [11:0] zeroCount;
    wire [11:0] zeroLimit = altCriteria ? `CARRIER_ZEROS_ALT : `CARRIER_ZEROS_NORMAL;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            zeroCount <= 12'h000;
            rx_carrier_loss <= 1'b0;
        end else if (rxEdge) begin
            if (lineRxPos | lineRxNeg) begin
                zeroCount <= 12'h000;
                rx_carrier_loss <= 1'b0;
            end else if (zeroCount >= zeroLimit - 12'h001) begin
                rx_carrier_loss <= 1'b1;
            end else begin
                zeroCount <= zeroCount + 12'h001;
            end
        end
    end

    // CRC4 multiframe search timer, running from FAS sync until multiframe sync.
    reg [31:0] crc4Timer;
    reg crc4ShortFail;
    reg crc4LongFail;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            crc4Timer <= 32'h0000_0000;
            crc4ShortFail <= 1'b0;
            crc4LongFail <= 1'b0;
        end else if (!rxCrc4Enable || !fasSync || crc4MultiframeSync) begin
            crc4Timer <= 32'h0000_0000;
            crc4ShortFail <= 1'b0;
            crc4LongFail <= 1'b0;
        end else begin
            if (crc4Timer < CRC4_LONG_CYCLES)
                crc4Timer <= crc4Timer + 32'h0000_0001;
            if (crc4Timer >= CRC4_SHORT_CYCLES - 1)
                crc4ShortFail <= 1'b1;
            if (crc4Timer >= CRC4_LONG_CYCLES - 1)
                crc4LongFail <= 1'b1;
        end
    end

    wire rxAlarmCond = frameAlignLost | aisReceived | rx_carrier_loss;

    // Alarm, clock selection and serial output stage.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txAisActive <= 1'b0;
            txRemoteAlarm <= 1'b0;
            txClockFromRecovered <= 1'b0;
            rx_serial_out <= 1'b1;
            rxClockOut <= 1'b0;
        end else begin
            txAisActive <= autoAis & rxAlarmCond;
            txRemoteAlarm <= (autoRemote & (rxAlarmCond | crc4ShortFail)) | crc4LongFail;
            txClockFromRecovered <= next_fromRecovered;
            rx_serial_out <= (serialForce & frameAlignLost) ? 1'b1 : rxSerialIn;
            rxClockOut <= framerLoopback ? txClockLevel : rxClockLevel;
        end
    end

    // Line transmit path; all ones alternate polarity so the line stays balanced.
    reg aisPolarity;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_line_pos_out <= 1'b0;
            tx_line_neg_out <= 1'b0;
            aisPolarity <= 1'b0;
        end else if (lineAis) begin
            if (masterTick) begin
                tx_line_pos_out <= ~aisPolarity;
                tx_line_neg_out <= aisPolarity;
                aisPolarity <= ~aisPolarity;
            end
        end else if (remoteLoopback) begin
            if (rxEdge) begin
                tx_line_pos_out <= lineRxPos;
                tx_line_neg_out <= lineRxNeg;
            end
        end else if (formatterTick) begin
            if (txAisActive) begin
                tx_line_pos_out <= ~aisPolarity;
                tx_line_neg_out <= aisPolarity;
                aisPolarity <= ~aisPolarity;
            end else begin
                tx_line_pos_out <= txFormPos;
                tx_line_neg_out <= txFormNeg;
            end
        end
    end

    // Receive framer feed: formatter data, transmitted data or line data.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxFramerPos <= 1'b0;
            rxFramerNeg <= 1'b0;
        end else if (framerLoopback) begin
            if (formatterTick) begin
                rxFramerPos <= txFormPos;
                rxFramerNeg <= txFormNeg;
            end
        end else if (localLoopback) begin
            if (formatterTick) begin
                rxFramerPos <= tx_line_pos_out;
                rxFramerNeg <= tx_line_neg_out;
            end
        end else if (rxEdge) begin
            rxFramerPos <= lineRxPos;
            rxFramerNeg <= lineRxNeg;
        end
    end

    // Violation counting and periodic latch of the counters.
    reg [31:0] updateTimer;
    reg [15:0] violationCount;
    wire [31:0] updatePeriod = fastUpdate ? FAST_UPDATE_CYCLES : ONE_SECOND_CYCLES;
    wire next_violation = countCodeViol ? cvEvent : bpvEvent;
    wire updateDue = updateTimer >= updatePeriod - 1;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            updateTimer <= 32'h0000_0000;
            violationCount <= 16'h0000;
            violationCountLatched <= 16'h0000;
            violationEvent <= 1'b0;
            errCountLatch <= 1'b0;
        end else begin
            violationEvent <= next_violation;
            errCountLatch <= updateDue;
            if (updateDue) begin
                updateTimer <= 32'h0000_0000;
                violationCountLatched <= violationCount;
                violationCount <= {15'h0000, next_violation};
            end else begin
                updateTimer <= updateTimer + 32'h0000_0001;
                if (next_violation && violationCount != 16'hffff)
                    violationCount <= violationCount + 16'h0001;
            end
        end
    end

    // Transmit channel monitor capture.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            tx_monitor_register <= 8'h00;
        else if (txChanValid && txChanNum == monitorChan)
            tx_monitor_register <= txChanData;
    end

endmodule // e1_loopback_alarm_control

// >>> pkg/e1_loopback_alarm_control_regs.vh
// Register map, field positions and timing constants of the E1 loopback and alarm control.
// Functional notes
// - Framer loopback bit set feeds transmit framer data into the receive framer path.
// - During framer loopback, normal transmit data still goes to the line outputs.
// - During framer loopback, receive clock output follows the transmit clock input.
// - Update select bit latches error counters each second, or every 62.5 ms.
// - Violation function bit picks bipolar violations at 0, code violations at 1.
// - Serial output force bit holds receive serial data high while alignment is lost.
// - Clock loss mux bit switches transmit to recovered clock when transmit clock stops.
// - Carrier loss after 255 zeros, or 2048 zeros with the alternate criteria bit.
// - Clock source select forces recovered receive clock; otherwise clock loss mux decides.
// - Automatic AIS sends AIS on frame loss, received AIS or carrier loss.
// - Automatic remote alarm on those conditions or CRC4 multiframe missing after 128 ms.
// - CRC4 multiframe sync still missing after 400 ms gives constant remote alarm.
// - Line AIS bit sends unframed all ones at master clock rate on line.
// - Five channel monitor bits pick the transmit channel copied to the monitor register.
// - Remote loopback sends receive line data straight back out the transmit line.
// - In remote loopback the receive framer still sees line data; formatter data dropped.
// - Local loopback transmits normally and feeds transmitted data to the receive path.
`ifndef E1_LOOPBACK_ALARM_CONTROL_REGS_VH
`define E1_LOOPBACK_ALARM_CONTROL_REGS_VH
`define REG_CTRL_ONE 8'h12
`define REG_CTRL_TWO 8'h13
`define REG_CTRL_THREE 8'h14
`define CTRL_RESET 8'h00
`define BIT_FRAMER_LOOPBACK 7
`define BIT_RX_CRC4_ENABLE 0
`define BIT_ERR_COUNT_UPDATE_SEL 7
`define BIT_VIOLATION_COUNT_FUNC_SEL 6
`define BIT_AUTO_AIS_ENABLE 5
`define BIT_AUTO_REMOTE_ALARM_ENABLE 4
`define BIT_RX_SERIAL_OUT_FORCE 3
`define BIT_TX_CLOCK_LOSS_MUX 2
`define BIT_CARRIER_LOSS_ALT_CRITERIA 1
`define BIT_TX_CLOCK_SOURCE_SEL 0
`define BIT_REMOTE_LOOPBACK 7
`define BIT_LOCAL_LOOPBACK 6
`define BIT_LINE_AIS_ENABLE 5
`define TX_CHAN_MONITOR_MSB 4
`define TX_CHAN_MONITOR_LSB 0
`define CLK_MHZ 50
`define ONE_SECOND_US 1000000
`define FAST_UPDATE_US 62500
`define CRC4_SHORT_US 128000
`define CRC4_LONG_US 400000
`define ONE_SECOND_CYCLES (`ONE_SECOND_US * `CLK_MHZ)
`define FAST_UPDATE_CYCLES (`FAST_UPDATE_US * `CLK_MHZ)
`define CRC4_SHORT_CYCLES (`CRC4_SHORT_US * `CLK_MHZ)
`define CRC4_LONG_CYCLES (`CRC4_LONG_US * `CLK_MHZ)
`define CARRIER_ZEROS_NORMAL 12'd255
`define CARRIER_ZEROS_ALT 12'd2048
`define TX_CLOCK_LOSS_CYCLES 64
`define MASTER_CLOCK_DIV 24
`endif

// >>> tb/e1_line_partner.sv
// Line-side partner: transmit clock, recovered clock and alternating receive marks.
`timescale 1ns/100ps
module e1_line_partner (
    input wire stopTx,
    input wire zeroLine,
    output logic txClk,
    output logic rxClk,
    output logic rxPos,
    output logic rxNeg
);
    initial begin
        txClk = 1'b0;
        rxClk = 1'b0;
        rxPos = 1'b0;
        rxNeg = 1'b0;
        #37;
        forever begin
            #80;
            rxClk = ~rxClk;
        end
    end
    // A stopped transmit clock parks low, like a dead oscillator.
    always begin
        #80;
        txClk = stopTx ? 1'b0 : ~txClk;
    end
    // Data moves on the falling edge so the rising edge samples settled marks.
    always @(negedge rxClk) begin
        rxPos <= !zeroLine && !rxPos;
        rxNeg <= !zeroLine && rxPos;
    end
endmodule // e1_line_partner

// >>> tb/e1_loopback_alarm_control_chk.sv
// Port-level assertions for the E1 loopback and alarm control.
`timescale 1ns/100ps
module e1_loopback_alarm_control_chk (
    input wire clk,
    input wire reset_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire [7:0] regRdData,
    input wire rxSerialIn,
    input wire frameAlignLost,
    input wire aisReceived,
    input wire bpvEvent,
    input wire cvEvent,
    input wire txChanValid,
    input wire rx_serial_out,
    input wire rx_carrier_loss,
    input wire txAisActive,
    input wire violationEvent,
    input wire errCountLatch,
    input wire [7:0] tx_monitor_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ais_has_cause: assert property (txAisActive |-> $past(frameAlignLost || aisReceived)
        || rx_carrier_loss || $past(rx_carrier_loss)) else $error("AIS without a cause");
    a_ais_quiet_line: assert property ((!frameAlignLost && !aisReceived
        && !rx_carrier_loss) [*2] |-> !txAisActive) else $error("AIS with no cause");
    a_write_read_back: assert property (regWrite && regAddr == 8'h13 ##1
        !regWrite && regAddr == 8'h13 |=> regRdData == $past(regWrData, 2))
        else $error("register read back wrong");
    a_unmapped_zero: assert property (regAddr > 8'h14 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_serial_pass: assert property (!frameAlignLost |=> rx_serial_out == $past(rxSerialIn))
        else $error("serial data not passed");
    a_viol_has_cause: assert property (violationEvent |-> $past(bpvEvent || cvEvent))
        else $error("violation without event");
    a_latch_spacing: assert property (errCountLatch |=> !errCountLatch [*8])
        else $error("latch pulses too close");
    a_monitor_valid: assert property (!$stable(tx_monitor_register) |-> $past(txChanValid))
        else $error("monitor changed without data");
    c_ais: cover property (txAisActive);
    c_carrier: cover property (rx_carrier_loss);
    c_latch: cover property (errCountLatch);
endmodule // e1_loopback_alarm_control_chk
bind e1_loopback_alarm_control e1_loopback_alarm_control_chk u_chk (.clk, .reset_n, .regAddr,
    .regWrData, .regWrite, .regRdData, .rxSerialIn, .frameAlignLost, .aisReceived, .bpvEvent,
    .cvEvent, .txChanValid, .rx_serial_out, .rx_carrier_loss, .txAisActive, .violationEvent,
    .errCountLatch, .tx_monitor_register);

// >>> tb/tb_top.sv
// Self-checking bench for the E1 loopback and alarm control.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, frameStart = 1'b0, stopTx = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, txChanData = 8'h00;
    logic [4:0] txChanNum = 5'h00;
    logic txFormPos = 1'b0, txFormNeg = 1'b0, rxSerialIn = 1'b0, frameAlignLost = 1'b0;
    logic aisReceived = 1'b0, fasSync = 1'b0, crc4MultiframeSync = 1'b0, bpvEvent = 1'b0;
    logic cvEvent = 1'b0, txChanValid = 1'b0, zeroLine = 1'b0;
    wire tx_clock_in, rxRecoveredClock, rx_line_pos_in, rx_line_neg_in;
    wire [7:0] regRdData, tx_monitor_register;
    wire [15:0] violationCountLatched;
    wire tx_line_pos_out, tx_line_neg_out, rxFramerPos, rxFramerNeg, rxClockOut, rx_serial_out;
    wire rx_carrier_loss, txAisActive, txRemoteAlarm, txClockFromRecovered, txClockLost;
    wire violationEvent, errCountLatch;
    int err_total = 0;
    int compares = 0;
    always #10 clk = ~clk;
    e1_line_partner u_line (.stopTx, .zeroLine, .txClk(tx_clock_in), .rxClk(rxRecoveredClock),
        .rxPos(rx_line_pos_in), .rxNeg(rx_line_neg_in));
    e1_loopback_alarm_control #(.ONE_SECOND_CYCLES(2000), .FAST_UPDATE_CYCLES(200),
        .CRC4_SHORT_CYCLES(300), .CRC4_LONG_CYCLES(900)) dut (.clk, .reset_n, .regAddr,
        .regWrData, .regWrite, .regRdData, .frameStart, .tx_clock_in, .rxRecoveredClock,
        .rx_line_pos_in, .rx_line_neg_in, .txFormPos, .txFormNeg, .rxSerialIn, .frameAlignLost,
        .aisReceived, .fasSync, .crc4MultiframeSync, .bpvEvent, .cvEvent, .txChanNum,
        .txChanData, .txChanValid, .tx_line_pos_out, .tx_line_neg_out, .rxFramerPos,
        .rxFramerNeg, .rxClockOut, .rx_serial_out, .rx_carrier_loss, .txAisActive, .txRemoteAlarm,
        .txClockFromRecovered, .txClockLost, .violationEvent, .errCountLatch,
        .violationCountLatched, .tx_monitor_register);
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // A write is followed by a frame pulse so the new setting becomes active.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        cyc(1);
        regWrite = 1'b0;
        frameStart = 1'b1;
        cyc(1);
        frameStart = 1'b0;
        cyc(2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        cyc(2);
        chk(16'(regRdData), 16'(e));
    endtask
    task automatic rises(input int which, input int n, output int r);
        logic prev, cur;
        r = 0;
        prev = 1'b1;
        repeat (n) begin
            cyc(1);
            cur = (which == 0) ? rxClockOut : (which == 1) ? tx_line_pos_out
                : (which == 2) ? rxFramerPos : (which == 3) ? tx_line_neg_out : rxFramerNeg;
            r += int'(cur === 1'b1 && prev === 1'b0);
            prev = cur;
        end
    endtask
    task automatic wait_hi(input int which, input int lim, output int n);
        n = 0;
        while ((which ? errCountLatch : rx_carrier_loss) !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        if (n == lim) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic t_regs();
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
        wr(8'h13, 8'ha5);
        rd(8'h13, 8'ha5);
        wr(8'h14, 8'h5a);
        rd(8'h14, 8'h5a);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'h00);
    endtask
    task automatic t_alarms(input logic [7:0] ctl);
        wr(8'h13, ctl);
        frameAlignLost = 1'b1;
        rxSerialIn = 1'b0;
        cyc(3);
        chk(16'(txAisActive), 16'(ctl[5]));
        chk(16'(txRemoteAlarm), 16'(ctl[4]));
        chk(16'(rx_serial_out), 16'(ctl[3]));
        frameAlignLost = 1'b0;
        aisReceived = 1'b1;
        cyc(3);
        chk(16'(txAisActive), 16'(ctl[5]));
        aisReceived = 1'b0;
        cyc(3);
        chk({15'h0, txAisActive | txRemoteAlarm | rx_serial_out}, 16'h0);
    endtask
    task automatic t_viol(input logic b, input logic e);
        int hits;
        hits = 0;
        bpvEvent = b;
        cvEvent = !b;
        cyc(1);
        bpvEvent = 1'b0;
        cvEvent = 1'b0;
        repeat (3) begin
            hits += int'(violationEvent === 1'b1);
            cyc(1);
        end
        chk(16'(hits), 16'(e));
    endtask
    task automatic t_crc4();
        wr(8'h13, 8'h10);
        wr(8'h12, 8'h01);
        fasSync = 1'b1;
        cyc(250);
        chk(16'(txRemoteAlarm), 16'h0);
        cyc(100);
        chk(16'(txRemoteAlarm), 16'h1);
        wr(8'h13, 8'h00);
        cyc(10);
        chk(16'(txRemoteAlarm), 16'h0);
        cyc(600);
        chk(16'(txRemoteAlarm), 16'h1);
        crc4MultiframeSync = 1'b1;
        cyc(3);
        chk(16'(txRemoteAlarm), 16'h0);
        crc4MultiframeSync = 1'b0;
        fasSync = 1'b0;
        wr(8'h12, 8'h00);
    endtask
    task automatic t_loops();
        int r;
        txFormPos = 1'b1;
        wr(8'h12, 8'h80);
        cyc(30);
        chk({15'h0, rxFramerPos & tx_line_pos_out}, 16'h1);
        stopTx = 1'b1;
        cyc(6);
        rises(0, 80, r);
        chk(16'(r), 16'h0);
        stopTx = 1'b0;
        rises(0, 80, r);
        chk(16'(r > 5), 16'h1);
        wr(8'h12, 8'h00);
        txFormPos = 1'b0;
        wr(8'h14, 8'h80);
        rises(1, 80, r);
        chk(16'(r > 2), 16'h1);
        rises(2, 80, r);
        chk(16'(r > 2), 16'h1);
        rises(3, 80, r);
        chk(16'(r > 2), 16'h1);
        rises(4, 80, r);
        chk(16'(r > 2), 16'h1);
        wr(8'h14, 8'h20);
        zeroLine = 1'b1;
        rises(1, 200, r);
        chk(16'(r > 2), 16'h1);
        zeroLine = 1'b0;
        wr(8'h14, 8'h40);
        txFormPos = 1'b1;
        cyc(30);
        chk({15'h0, rxFramerPos & tx_line_pos_out}, 16'h1);
        txFormPos = 1'b0;
    endtask
    task automatic t_clk();
        wr(8'h13, 8'h01);
        chk(16'(txClockFromRecovered), 16'h1);
        wr(8'h13, 8'h04);
        chk(16'(txClockFromRecovered), 16'h0);
        stopTx = 1'b1;
        cyc(100);
        chk({14'h0, txClockLost, txClockFromRecovered}, 16'h3);
        wr(8'h13, 8'h00);
        chk(16'(txClockFromRecovered), 16'h0);
        stopTx = 1'b0;
        cyc(20);
    endtask
    task automatic t_carrier(input logic [7:0] ctl, input int zeros);
        int n;
        wr(8'h13, ctl);
        zeroLine = 1'b1;
        wait_hi(0, 20000, n);
        chk(16'(n > (zeros - 2) * 8 && n < (zeros + 2) * 8), 16'h1);
        cyc(2);
        chk(16'(txAisActive), 16'(ctl[5]));
        zeroLine = 1'b0;
        cyc(40);
        chk(16'(rx_carrier_loss), 16'h0);
    endtask
    task automatic t_latch(input logic [7:0] ctl, input int per);
        int n;
        wr(8'h13, ctl);
        wait_hi(1, 5000, n);
        cyc(1);
        // Three bipolar violations inside one period must show up in the next latch.
        repeat (3) begin
            bpvEvent = 1'b1;
            cyc(1);
            bpvEvent = 1'b0;
            cyc(1);
        end
        wait_hi(1, 5000, n);
        chk(16'(n + 7), 16'(per));
        chk(violationCountLatched, 16'h0003);
    endtask
    initial begin
        cyc(8);
        reset_n = 1'b1;
        cyc(2);
        t_regs();
        t_alarms(8'h38);
        t_alarms(8'h00);
        wr(8'h13, 8'h00);
        t_viol(1'b1, 1'b1);
        t_viol(1'b0, 1'b0);
        wr(8'h13, 8'h40);
        t_viol(1'b1, 1'b0);
        t_viol(1'b0, 1'b1);
        t_crc4();
        t_loops();
        wr(8'h14, 8'h11);
        txChanNum = 5'h11;
        txChanData = 8'h3c;
        txChanValid = 1'b1;
        cyc(1);
        txChanNum = 5'h01;
        txChanData = 8'h77;
        cyc(1);
        txChanValid = 1'b0;
        cyc(2);
        chk(16'(tx_monitor_register), 16'h3c);
        wr(8'h14, 8'h00);
        t_clk();
        t_carrier(8'h20, 255);
        t_carrier(8'h02, 2048);
        t_latch(8'h00, 2000);
        t_latch(8'h80, 200);
        summarize();
    end
endmodule // tb_top
